// ### vint_pkg.sv
// constants, types and helpers shared by the vme interrupter files
package vint_pkg;

    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MAP_A = 8'h08;
    localparam logic [7:0] OFF_MAP_B = 8'h0c;
    localparam logic [7:0] OFF_MAP_C = 8'h10;
    localparam logic [7:0] OFF_VECTOR = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_ACK_STAT = 8'h1c;

    // writable bits of each register
    localparam logic [31:0] MASK_SRC = 32'h00fe_ffff;
    localparam logic [31:0] MASK_MAP_A = 32'h7777_7777;
    localparam logic [31:0] MASK_MAP_BC = 32'h0000_7777;
    localparam logic [31:0] MASK_VECTOR = 32'h0000_00fe;
    localparam logic [31:0] MASK_CTRL = 32'h0000_0073;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

    // source bit positions in enable and status
    localparam int BIT_PCI = 0;
    localparam int BIT_DMA = 8;
    localparam int BIT_VME_BUS_ERROR_SOURCE = 9;
    localparam int BIT_PCI_ABORT_SOURCE = 10;
    localparam int BIT_MBOX = 11;
    localparam int BIT_SOFT_MAPPED = 15;
    localparam int BIT_SOFT_FIXED = 16;
    localparam int NUM_MAPPED = 16;

    // control register fields, and the mapped soft level field of map_b
    localparam int BIT_SYSCON = 0;
    localparam int BIT_ACK_EN = 1;
    localparam int BIT_ACK_LINE = 4;
    localparam int BIT_MAP_SOFT = 12;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IACK_IDLE = 2'h0,
        IACK_RESPOND = 2'h1,
        IACK_RELEASE = 2'h3,
        IACK_PASS = 2'h2
    } vint_iack_state_t;

    // one line per level, level zero selects none
    function automatic logic [7:1] lvl_onehot(input logic [2:0] lvl);
        logic [7:0] v;
        v = 8'h01 << lvl;
        return v[7:1];
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

endpackage

// ### vint_level_map.sv
// fans mapped interrupt sources into the seven vme request lines
`timescale 1ns/10ps
module vint_level_map #(
    parameter int N = 16
) (
    // sources and their 3-bit levels
    input wire logic [N-1:0] src,
    input wire logic [3*N-1:0] lvl,
    // per-level request
    output logic [7:1] req
);

    always_comb begin
        req = 7'h00;
        for (int i = 0; i < N; i++) begin
            if (src[i]) begin
                req = req | vint_pkg::lvl_onehot(lvl[3*i +: 3]);
            end
        end
    end

endmodule

// ### vint_iack_responder.sv
// answers vme acknowledge cycles with the status/id and passes the chain
`timescale 1ns/10ps
module vint_iack_responder (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // request state
    input wire logic [7:1] req_lines,
    input wire logic [7:1] soft_lines,
    input wire logic [6:0] vector_hi,
    input wire logic syscon,
    // acknowledge cycle
    input wire logic iack_strobe,
    input wire logic [2:0] iack_level,
    input wire logic iack_in_n,
    output logic iack_out_n,
    output logic vec_valid,
    output logic [7:0] vec_data,
    // release
    output logic ack_done,
    output logic [2:0] ack_level,
    output logic ack_soft
);

    vint_pkg::vint_iack_state_t state_reg;
    logic [7:0] req8;
    logic [7:0] soft8;
    logic chain_ok;

    assign req8 = {req_lines, 1'b0};
    assign soft8 = {soft_lines, 1'b0};
    assign chain_ok = syscon | ~iack_in_n;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= vint_pkg::IACK_IDLE;
            iack_out_n <= 1'b1;
            vec_valid <= 1'b0;
            vec_data <= 8'h00;
            ack_done <= 1'b0;
            ack_level <= 3'h0;
            ack_soft <= 1'b0;
        end else begin
            ack_done <= 1'b0;
            case (state_reg)
                vint_pkg::IACK_IDLE: begin
                    if (iack_strobe && chain_ok && req8[iack_level]) begin
                        state_reg <= vint_pkg::IACK_RESPOND;
                        vec_valid <= 1'b1;
                        vec_data <= {vector_hi, ~soft8[iack_level]};
                        ack_level <= iack_level;
                        ack_soft <= soft8[iack_level];
                    end else if (iack_strobe && chain_ok) begin
                        state_reg <= vint_pkg::IACK_PASS;
                        iack_out_n <= 1'b0;
                    end
                end
                vint_pkg::IACK_RESPOND: begin
                    if (!iack_strobe) begin
                        state_reg <= vint_pkg::IACK_RELEASE;
                        vec_valid <= 1'b0;
                        ack_done <= 1'b1;
                    end
                end
                vint_pkg::IACK_RELEASE: begin
                    state_reg <= vint_pkg::IACK_IDLE;
                end
                vint_pkg::IACK_PASS: begin
                    if (!iack_strobe) begin
                        state_reg <= vint_pkg::IACK_IDLE;
                        iack_out_n <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= vint_pkg::IACK_IDLE;
                end
            endcase
        end
    end

endmodule

// ### vint_interrupter.sv
// vme interrupter with pci line inputs, register file on axi4-lite
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module vint_interrupter (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    // axi4-lite write response
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    // axi4-lite read data
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // interrupt sources
    input wire logic [7:0] pci_irq_line_n,
    input wire logic dma_event,
    input wire logic vme_bus_error_source,
    input wire logic pci_abort_source,
    input wire logic [3:0] mailbox_sources,
    // vme request lines, active high to the open-collector drivers
    output logic [7:1] vme_request_out,
    // vme acknowledge cycle
    input wire logic iack_strobe,
    input wire logic [2:0] iack_level,
    input wire logic iack_in_n,
    output logic iack_out_n,
    output logic iack_vector_valid,
    output logic [7:0] iack_vector,
    // soft acknowledge towards the pci lines
    output logic [7:0] soft_ack_pci_irq
);

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [31:0] vme_irq_enable_reg;
    logic [31:0] vme_irq_status_reg;
    logic [31:0] vme_irq_status_next;
    logic [31:0] vme_irq_level_map_a;
    logic [31:0] vme_irq_level_map_b;
    logic [31:0] vme_irq_level_map_c;
    logic [31:0] vector_out_reg;
    logic [31:0] ctrl_reg;
    logic soft_ack_done_event;
    logic soft_ack_stat_reg;
    logic [7:1] vme_request_reg;
    logic [7:0] soft_ack_irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_go;
    logic [31:0] wmask;
    logic wr_hit;
    logic [31:0] rd_val;
    logic rd_hit;
    logic first_cycle;

    // address and data may arrive in either order; each is held until both are in
    assign wr_go = !awready_reg && !wready_reg && !bvalid_reg && !first_cycle;
    assign wmask = vint_pkg::strb_mask(wstrb_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            waddr_reg <= 8'h00;
        end else if (s_axil_awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            waddr_reg <= s_axil_awaddr;
        end else if ((bvalid_reg && s_axil_bready) || first_cycle) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axil_wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            wdata_reg <= s_axil_wdata;
            wstrb_reg <= s_axil_wstrb;
        end else if ((bvalid_reg && s_axil_bready) || first_cycle) begin
            wready_reg <= 1'b1;
        end
    end

    always_comb begin
        case (waddr_reg)
            vint_pkg::OFF_ENABLE, vint_pkg::OFF_STATUS, vint_pkg::OFF_MAP_A,
            vint_pkg::OFF_MAP_B, vint_pkg::OFF_MAP_C, vint_pkg::OFF_VECTOR,
            vint_pkg::OFF_CTRL, vint_pkg::OFF_ACK_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= vint_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? vint_pkg::RESP_OKAY : vint_pkg::RESP_SLVERR;
        end else if (s_axil_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // reserved bits read as zero; unmapped reads give zero with slverr
    always_comb begin
        rd_hit = 1'b1;
        case (s_axil_araddr)
            vint_pkg::OFF_ENABLE: rd_val = vme_irq_enable_reg;
            vint_pkg::OFF_STATUS: rd_val = vme_irq_status_reg;
            vint_pkg::OFF_MAP_A: rd_val = vme_irq_level_map_a;
            vint_pkg::OFF_MAP_B: rd_val = vme_irq_level_map_b;
            vint_pkg::OFF_MAP_C: rd_val = vme_irq_level_map_c;
            vint_pkg::OFF_VECTOR: rd_val = vector_out_reg;
            vint_pkg::OFF_CTRL: rd_val = ctrl_reg;
            vint_pkg::OFF_ACK_STAT: rd_val = {31'h0000_0000, soft_ack_stat_reg};
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= vint_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (s_axil_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= rd_hit ? vint_pkg::RESP_OKAY : vint_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axil_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end else if (!rvalid_reg) begin
            arready_reg <= 1'b1;
        end
    end

    assign s_axil_awready = awready_reg;
    assign s_axil_wready = wready_reg;
    assign s_axil_bvalid = bvalid_reg;
    assign s_axil_bresp = bresp_reg;
    assign s_axil_arready = arready_reg;
    assign s_axil_rvalid = rvalid_reg;
    assign s_axil_rresp = rresp_reg;
    assign s_axil_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // programmable registers

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask);
        return ((old & ~wmask) | (wdata_reg & wmask)) & mask;
    endfunction

    function automatic logic hit(input logic [7:0] off);
        return wr_go && (waddr_reg == off);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vme_irq_enable_reg <= vint_pkg::RESET_VALUE;
        end else if (hit(vint_pkg::OFF_ENABLE)) begin
            vme_irq_enable_reg <= merge(vme_irq_enable_reg, vint_pkg::MASK_SRC);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vme_irq_level_map_a <= vint_pkg::RESET_VALUE;
            vme_irq_level_map_b <= vint_pkg::RESET_VALUE;
            vme_irq_level_map_c <= vint_pkg::RESET_VALUE;
        end else begin
            if (hit(vint_pkg::OFF_MAP_A)) begin
                vme_irq_level_map_a <= merge(vme_irq_level_map_a, vint_pkg::MASK_MAP_A);
            end
            if (hit(vint_pkg::OFF_MAP_B)) begin
                vme_irq_level_map_b <= merge(vme_irq_level_map_b, vint_pkg::MASK_MAP_BC);
            end
            if (hit(vint_pkg::OFF_MAP_C)) begin
                vme_irq_level_map_c <= merge(vme_irq_level_map_c, vint_pkg::MASK_MAP_BC);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_out_reg <= vint_pkg::RESET_VALUE;
            ctrl_reg <= vint_pkg::RESET_VALUE;
        end else begin
            if (hit(vint_pkg::OFF_VECTOR)) begin
                vector_out_reg <= merge(vector_out_reg, vint_pkg::MASK_VECTOR);
            end
            if (hit(vint_pkg::OFF_CTRL)) begin
                ctrl_reg <= merge(ctrl_reg, vint_pkg::MASK_CTRL);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status bits

    logic [31:0] enable_wr;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic ack_done;
    logic [2:0] ack_level;
    logic ack_soft;

    // soft requests trigger on a written 0 to 1 edge of their enable bits
    assign enable_wr = hit(vint_pkg::OFF_ENABLE) ? merge(vme_irq_enable_reg, vint_pkg::MASK_SRC) : vme_irq_enable_reg;

    always_comb begin
        set_bits = 32'h0000_0000;
        set_bits[vint_pkg::BIT_PCI +: 8] = ~pci_irq_line_n;
        set_bits[vint_pkg::BIT_DMA] = dma_event;
        set_bits[vint_pkg::BIT_VME_BUS_ERROR_SOURCE] = vme_bus_error_source;
        set_bits[vint_pkg::BIT_PCI_ABORT_SOURCE] = pci_abort_source;
        set_bits[vint_pkg::BIT_MBOX +: 4] = mailbox_sources;
        set_bits[vint_pkg::BIT_SOFT_MAPPED] = enable_wr[vint_pkg::BIT_SOFT_MAPPED]
            & ~vme_irq_enable_reg[vint_pkg::BIT_SOFT_MAPPED];
        set_bits[vint_pkg::BIT_SOFT_FIXED +: 8] = enable_wr[vint_pkg::BIT_SOFT_FIXED +: 8]
            & ~vme_irq_enable_reg[vint_pkg::BIT_SOFT_FIXED +: 8];
        set_bits = set_bits & vint_pkg::MASK_SRC;
    end

    always_comb begin
        clr_bits = 32'h0000_0000;
        if (hit(vint_pkg::OFF_STATUS)) begin
            clr_bits = wdata_reg & wmask;
        end
        if (ack_done && ack_soft) begin
            clr_bits[vint_pkg::BIT_SOFT_FIXED + 32'(ack_level)] = 1'b1;
            if (vme_irq_level_map_b[vint_pkg::BIT_MAP_SOFT +: 3] == ack_level) begin
                clr_bits[vint_pkg::BIT_SOFT_MAPPED] = 1'b1;
            end
        end
    end

    // a new event in the clearing cycle keeps its bit set
    assign vme_irq_status_next = ((vme_irq_status_reg & ~clr_bits) | set_bits) & vint_pkg::MASK_SRC;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vme_irq_status_reg <= vint_pkg::RESET_VALUE;
        end else begin
            vme_irq_status_reg <= vme_irq_status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request lines

    logic [vint_pkg::NUM_MAPPED-1:0] map_src;
    logic [3*vint_pkg::NUM_MAPPED-1:0] map_lvl;
    logic [7:1] mapped_req;
    logic [7:1] soft_lines;

    always_comb begin
        map_src = vme_irq_status_next[15:0] & vme_irq_enable_reg[15:0];
        map_src[vint_pkg::BIT_SOFT_MAPPED] = vme_irq_status_next[vint_pkg::BIT_SOFT_MAPPED];
        for (int i = 0; i < 8; i++) begin
            map_lvl[3*i +: 3] = vme_irq_level_map_a[4*i +: 3];
        end
        for (int i = 0; i < 4; i++) begin
            map_lvl[3*(vint_pkg::BIT_DMA+i) +: 3] = vme_irq_level_map_b[4*i +: 3];
            map_lvl[3*(vint_pkg::BIT_MBOX+i) +: 3] = vme_irq_level_map_c[4*i +: 3];
        end
        // fourth map_b field belongs to the mapped soft request, not mailbox 0
        map_lvl[3*vint_pkg::BIT_MBOX +: 3] = vme_irq_level_map_c[2:0];
        map_lvl[3*vint_pkg::BIT_SOFT_MAPPED +: 3] = vme_irq_level_map_b[vint_pkg::BIT_MAP_SOFT +: 3];
    end

    vint_level_map #(
        .N(vint_pkg::NUM_MAPPED)
    ) u_map (
        .src(map_src),
        .lvl(map_lvl),
        .req(mapped_req)
    );

    assign soft_lines = vme_irq_status_next[vint_pkg::BIT_SOFT_FIXED+1 +: 7]
        | (vme_irq_status_next[vint_pkg::BIT_SOFT_MAPPED]
        ? vint_pkg::lvl_onehot(vme_irq_level_map_b[vint_pkg::BIT_MAP_SOFT +: 3]) : 7'h00);

    // computed from the next status so line and bit drop together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vme_request_reg <= 7'h00;
        end else begin
            vme_request_reg <= mapped_req | vme_irq_status_next[vint_pkg::BIT_SOFT_FIXED+1 +: 7];
        end
    end

    assign vme_request_out = vme_request_reg;

    ////////////////////////////////////////////////////////////////////////
    // acknowledge cycle

    logic [7:1] soft_lines_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_lines_reg <= 7'h00;
        end else begin
            soft_lines_reg <= soft_lines;
        end
    end

    vint_iack_responder u_iack (
        .aclk(aclk),
        .aresetn(aresetn),
        .req_lines(vme_request_reg),
        .soft_lines(soft_lines_reg),
        .vector_hi(vector_out_reg[7:1]),
        .syscon(ctrl_reg[vint_pkg::BIT_SYSCON]),
        .iack_strobe(iack_strobe),
        .iack_level(iack_level),
        .iack_in_n(iack_in_n),
        .iack_out_n(iack_out_n),
        .vec_valid(iack_vector_valid),
        .vec_data(iack_vector),
        .ack_done(ack_done),
        .ack_level(ack_level),
        .ack_soft(ack_soft)
    );

    ////////////////////////////////////////////////////////////////////////
    // soft acknowledge event towards pci

    assign soft_ack_done_event = ack_done && ack_soft;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_ack_stat_reg <= 1'b0;
        end else if (soft_ack_done_event) begin
            soft_ack_stat_reg <= 1'b1;
        end else if (hit(vint_pkg::OFF_ACK_STAT) && wmask[0] && wdata_reg[0]) begin
            soft_ack_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_ack_irq_reg <= 8'h00;
        end else begin
            soft_ack_irq_reg <= (soft_ack_stat_reg && ctrl_reg[vint_pkg::BIT_ACK_EN])
                ? 8'(8'h01 << ctrl_reg[vint_pkg::BIT_ACK_LINE +: 3]) : 8'h00;
        end
    end

    assign soft_ack_pci_irq = soft_ack_irq_reg;

endmodule

// ### vint_chk.sv
// port-level checks for the vme interrupter
`timescale 1ns/10ps
module vint_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi answers
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arready,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // request lines and acknowledge
    input wire logic [7:1] vme_request_out,
    input wire logic iack_strobe,
    input wire logic [2:0] iack_level,
    input wire logic iack_out_n,
    input wire logic iack_vector_valid,
    input wire logic [7:0] iack_vector
);
    logic ours;
    // level zero has no line, guard the index
    assign ours = (iack_level != 3'h0) && vme_request_out[iack_level];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_ANSWER_OURS: assert property ($rose(iack_vector_valid) |-> $past(iack_strobe) && $past(ours))
        else $error("vector given without a request at that level");
    AST_ANSWER_OR_PASS: assert property (!(iack_vector_valid && !iack_out_n))
        else $error("vector and chain pass at once");
    AST_PASS_NOT_OURS: assert property ($fell(iack_out_n) |-> $past(iack_strobe) && !$past(ours))
        else $error("chain passed while requesting that level");
    AST_VECTOR_STEADY: assert property (iack_vector_valid |=> !iack_vector_valid || $stable(iack_vector))
        else $error("vector changed while driven");
    AST_RELEASE: assert property ($fell(iack_strobe) |-> ##[1:2] (!iack_vector_valid && iack_out_n))
        else $error("acknowledge outputs not released");
    AST_ONE_BRESP: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
        else $error("write response repeated");
    AST_ONE_RRESP: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
        else $error("read response repeated");
    AST_READ_BUSY: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read address taken while data pending");
    cover property ($rose(iack_vector_valid) && !iack_vector[0]);
    cover property ($rose(iack_vector_valid) && iack_vector[0]);
    cover property ($fell(vme_request_out[3]));
endmodule
bind vint_interrupter vint_chk chk (.aclk, .aresetn, .s_axil_bvalid, .s_axil_bready, .s_axil_arready,
    .s_axil_rvalid, .s_axil_rready, .vme_request_out, .iack_strobe, .iack_level, .iack_out_n,
    .iack_vector_valid, .iack_vector);

// ### vint_handler.sv
// vme interrupt handler board running acknowledge cycles
`timescale 1ns/10ps
module vint_handler (
    // clock
    input wire logic aclk,
    // answers
    input wire logic iack_out_n,
    input wire logic iack_vector_valid,
    input wire logic [7:0] iack_vector,
    // acknowledge cycle
    output logic iack_strobe = 1'b0,
    output logic [2:0] iack_level = 3'h0,
    output logic iack_in_n = 1'b1
);
    logic passed = 1'b0;
    task automatic ack(input logic [2:0] l, input logic chain, input int hold, output logic [7:0] vec,
        output logic got);
        int n;
        @(posedge aclk);
        iack_level <= l;
        iack_in_n <= !chain;
        iack_strobe <= 1'b1;
        got = 1'b0;
        vec = 8'h00;
        // bus timeout of the handler when nobody answers
        for (n = 0; n < 8 && !got && iack_out_n; n++) begin
            @(posedge aclk);
            got = iack_vector_valid;
            vec = iack_vector;
        end
        passed = !iack_out_n;
        repeat (hold) @(posedge aclk);
        iack_strobe <= 1'b0;
        iack_in_n <= 1'b1;
        iack_level <= ~l;
        repeat (3) @(posedge aclk);
    endtask
endmodule

// ### test_vme_interrupter_with_pci_inputs.sv
// self-checking bench for the vme interrupter
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module test_vme_interrupter_with_pci_inputs;
    logic aclk = 0, aresetn = 0, s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
    logic s_axil_arvalid = 0, s_axil_rready = 0, dma_event = 0, vme_bus_error_source = 0, pci_abort_source = 0;
    logic [7:0] s_axil_awaddr = '0, s_axil_araddr = '0, pci_irq_line_n = 8'hff;
    logic [31:0] s_axil_wdata = '0, s_axil_rdata, rd;
    logic [3:0] s_axil_wstrb = 4'hf, mailbox_sources = '0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, hit;
    logic iack_strobe, iack_in_n, iack_out_n, iack_vector_valid;
    logic [1:0] s_axil_bresp, s_axil_rresp, rs;
    logic [7:1] vme_request_out;
    logic [2:0] iack_level;
    logic [7:0] iack_vector, soft_ack_pci_irq, v, vec_hi;
    int err_count = 0, tests_run = 0, seed = 7, ln, lv;
    initial forever #4 aclk = ~aclk;
    vint_interrupter DUT (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
        .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
        .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid,
        .s_axil_rready, .pci_irq_line_n, .dma_event, .vme_bus_error_source, .pci_abort_source, .mailbox_sources,
        .vme_request_out, .iack_strobe, .iack_level, .iack_in_n, .iack_out_n, .iack_vector_valid, .iack_vector,
        .soft_ack_pci_irq);
    vint_handler hnd (.aclk, .iack_out_n, .iack_vector_valid, .iack_vector, .iack_strobe, .iack_level,
        .iack_in_n);
    function automatic logic [7:1] oh(input int l);
        logic [7:0] t;
        t = 8'h01 << l;
        return t[7:1];
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1;
        s_axil_wvalid <= 1;
        s_axil_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 0;
            if (s_axil_wready) s_axil_wvalid <= 0;
        end while (!s_axil_bvalid);
        rs = s_axil_bresp;
        s_axil_bready <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1;
        s_axil_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axil_arready) s_axil_arvalid <= 0;
        end while (!s_axil_rvalid);
        rd = s_axil_rdata;
        rs = s_axil_rresp;
        s_axil_rready <= 0;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        for (int a = 0; a <= 32; a += 4) begin
            rd_reg(a[7:0]);
            `CHK({rd, rs}, {vint_pkg::RESET_VALUE, (a == 32) ? vint_pkg::RESP_SLVERR : vint_pkg::RESP_OKAY})
        end
        wr(8'h20, 32'hffff_ffff);
        `CHK(rs, vint_pkg::RESP_SLVERR)
        ln = 1 + $unsigned($random(seed)) % 7;
        lv = 1 + $unsigned($random(seed)) % 7;
        vec_hi = 8'($random(seed)) & 8'hfe;
        wr(vint_pkg::OFF_VECTOR, {24'h0, vec_hi});
        // line 0 stays at level zero
        wr(vint_pkg::OFF_MAP_A, 32'(lv) << (4 * ln));
        wr(vint_pkg::OFF_ENABLE, 32'h0000_00ff);
        pci_irq_line_n <= ~(8'h01 << ln) & 8'hfe;
        mailbox_sources <= 4'h1;
        repeat (2) @(posedge aclk);
        mailbox_sources <= 4'h0;
        `CHK(vme_request_out, oh(lv))
        rd_reg(vint_pkg::OFF_STATUS);
        `CHK(rd, 32'h0000_0801 | (32'h1 << ln))
        hnd.ack(lv[2:0], 1'b1, 2, v, hit);
        `CHK({hit, v}, {1'b1, vec_hi | 8'h01})
        wr(vint_pkg::OFF_STATUS, 32'h1 << ln);
        repeat (2) @(posedge aclk);
        `CHK(vme_request_out, oh(lv))
        pci_irq_line_n <= 8'hff;
        wr(vint_pkg::OFF_STATUS, 32'h0000_ffff);
        repeat (2) @(posedge aclk);
        `CHK(vme_request_out, 7'h0)
        hnd.ack(lv[2:0], 1'b1, 1, v, hit);
        `CHK({hit, hnd.passed}, 2'b01)
        // soft-ack event onto pci line 5
        wr(vint_pkg::OFF_CTRL, 32'h0000_0052);
        for (int n = 1; n <= 7; n++) begin
            wr(vint_pkg::OFF_ENABLE, 32'h0);
            wr(vint_pkg::OFF_ENABLE, 32'h1 << (16 + n));
            repeat (2) @(posedge aclk);
            `CHK(vme_request_out, oh(n))
            hnd.ack(n[2:0], 1'b1, n, v, hit);
            `CHK({hit, v}, {1'b1, vec_hi})
            repeat (3) @(posedge aclk);
            rd_reg(vint_pkg::OFF_STATUS);
            `CHK({vme_request_out, rd}, 39'h0)
        end
        `CHK(soft_ack_pci_irq, 8'h20)
        rd_reg(vint_pkg::OFF_ACK_STAT);
        `CHK(rd[0], 1'b1)
        // dma and mapped soft share level 3
        wr(vint_pkg::OFF_MAP_B, 32'h0000_3003);
        wr(vint_pkg::OFF_ENABLE, 32'h0000_0100);
        wr(vint_pkg::OFF_ENABLE, 32'h0000_8100);
        dma_event <= 1;
        @(posedge aclk);
        dma_event <= 0;
        hnd.ack(3'h3, 1'b0, 1, v, hit);
        `CHK({hit, hnd.passed}, 2'b00)
        wr(vint_pkg::OFF_CTRL, 32'h0000_0001);
        hnd.ack(3'h3, 1'b0, 1, v, hit);
        `CHK({hit, v}, {1'b1, vec_hi})
        repeat (3) @(posedge aclk);
        rd_reg(vint_pkg::OFF_STATUS);
        `CHK({vme_request_out, rd}, {oh(3), 32'h0000_0100})
        tally_and_finish;
    end
endmodule
